// File: rtl/wdr_pkg.sv
// Purpose: Shared constants, types and timebase decoding for the watchdog.
// Assumes: One core clock at 100 MHz; the oscillator rate arrives as an enable.
// Notes: The timebase table follows the clock controller's timebase selection.
package wdr_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_PULSE_NS = 500;
  // A typical pulse length, so it is rounded down, never below one cycle.
  localparam int RST_PULSE_CYC = (RST_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 RST_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [5:0] RST_PULSE_LAST = 6'(RST_PULSE_CYC - 1);
  localparam logic [14:0] PRESCALE_BASE = 15'h4000;
  localparam logic [7:0] ALT_PERIOD_ADD = 8'hc0;
  localparam int ALT_PERIOD_SHIFT = 6;
  localparam logic [5:0] ACC_STEP = 6'h04;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam int CTRL_ACTIVATE_BIT = 7;
  localparam int CTRL_TOP_BIT = 6;
  localparam logic [6:0] CTRL_COUNT_RESET = 7'h7f;
  localparam logic CTRL_ACTIVATE_RESET = 1'b0;
  localparam logic [6:0] COUNT_EXPIRE = 7'h40;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Register bus request travels as one bundle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdr_bus_req_t;

  // Timebase selection code.
  typedef enum logic [1:0] {
    WDR_TB_2MS = 2'b00,
    WDR_TB_4MS = 2'b01,
    WDR_TB_10MS = 2'b10,
    WDR_TB_25MS = 2'b11
  } wdr_tb_t;

  // Number of short steps is governed by this per-timebase figure.
  function automatic logic [5:0] wdr_tb_msb(input wdr_tb_t sel);
    case (sel)
      WDR_TB_2MS: wdr_tb_msb = 6'd4;
      WDR_TB_4MS: wdr_tb_msb = 6'd8;
      WDR_TB_10MS: wdr_tb_msb = 6'd20;
      default: wdr_tb_msb = 6'd49;
    endcase
  endfunction

  // Per-timebase figure that sets the length of a boundary step.
  function automatic logic [5:0] wdr_tb_lsb(input wdr_tb_t sel);
    case (sel)
      WDR_TB_2MS: wdr_tb_lsb = 6'd59;
      WDR_TB_4MS: wdr_tb_lsb = 6'd53;
      WDR_TB_10MS: wdr_tb_lsb = 6'd35;
      default: wdr_tb_lsb = 6'd54;
    endcase
  endfunction

endpackage

// File: rtl/wdr_watchdog.sv
// Purpose: Watchdog built on a free-running 7-bit down-counter with reset output.
// Assumes: All inputs are synchronous to core_clk; osc_tick marks one oscillator cycle.
// Notes: Option straps are captured while reset is held.
`timescale 1ns/1ps
module wdr_watchdog
  import wdr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire wdr_pkg::wdr_bus_req_t bus_req,
  input wire logic osc_tick,
  input wire wdr_pkg::wdr_tb_t timebase_select,
  input wire logic halt_exec,
  input wire logic opt_hw_watchdog,
  input wire logic opt_halt_reset,
  output logic [7:0] rdata_q,
  output logic sys_reset_n_q,
  output logic wdg_active_q
);
  import wdr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic watchdog_activate_q;
  logic [6:0] cnt_q;
  logic [14:0] pre_q;
  logic [14:0] period_q;
  logic [5:0] acc_q;
  logic [5:0] pulse_q;
  logic pulsing_q;
  logic opt_hw_q;
  logic opt_halt_q;
  logic ctrl_sel;
  logic ctrl_wr;
  logic step;
  logic active_eff;
  logic expire_fire;
  logic sw_fire;
  logic halt_fire;
  logic fire;
  logic [5:0] tb_msb;
  logic [5:0] tb_lsb;
  logic [6:0] acc_next;
  logic boundary;
  logic [14:0] alt_period;
  logic [6:0] low_run_q;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // Address decode and the combined active state.
  assign ctrl_sel = (bus_req.addr == CTRL_OFFSET);
  assign ctrl_wr = bus_req.wr && ctrl_sel;
  assign active_eff = watchdog_activate_q || opt_hw_q;

  // Timebase figures for the prescaler.
  assign tb_msb = wdr_tb_msb(timebase_select);
  assign tb_lsb = wdr_tb_lsb(timebase_select);
  assign alt_period = {1'b0, ALT_PERIOD_ADD + {2'b00, tb_lsb},
                       6'(0)};

  // ****************************************************************
  // Option straps
  // ****************************************************************
  // Straps are sampled while reset is held, so they are stable afterwards.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      opt_hw_q <= opt_hw_watchdog;
      opt_halt_q <= opt_halt_reset;
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  // The prescaler is never cleared by a write; its phase at the write is
  // what spreads the real timeout between the minimum and maximum.
  assign step = osc_tick && (pre_q == period_q - 15'd1);
  assign acc_next = {1'b0, acc_q} + {1'b0, ACC_STEP};
  assign boundary = (acc_next >= {1'b0, tb_msb});

  // Oscillator cycle count within the current step.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pre_q <= '0;
    end else if (step) begin
      pre_q <= '0;
    end else if (osc_tick) begin
      pre_q <= pre_q + 15'd1;
    end
  end

  // Each step picks the length of the next: a boundary step shortens the one after it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      period_q <= PRESCALE_BASE;
      acc_q <= '0;
    end else if (step) begin
      if (boundary) begin
        acc_q <= 6'(acc_next - {1'b0, tb_msb});
        period_q <= alt_period;
      end else begin
        acc_q <= acc_next[5:0];
        period_q <= PRESCALE_BASE;
      end
    end
  end

  // ****************************************************************
  // Counter and activation
  // ****************************************************************
  // A write wins over a step in the same cycle, so a refresh is never lost.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= CTRL_COUNT_RESET;
    end else if (ctrl_wr) begin
      cnt_q <= bus_req.wdata[6:0];
    end else if (step) begin
      cnt_q <= cnt_q - 7'd1;
    end
  end

  // Activation can only be set; only reset clears it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      watchdog_activate_q <= CTRL_ACTIVATE_RESET;
    end else if (ctrl_wr && bus_req.wdata[CTRL_ACTIVATE_BIT]) begin
      watchdog_activate_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Reset generation
  // ****************************************************************
  // Three causes; a write counts as active if it sets activation itself.
  assign expire_fire = active_eff && step && !ctrl_wr &&
                       (cnt_q == COUNT_EXPIRE);
  assign sw_fire = ctrl_wr && !bus_req.wdata[CTRL_TOP_BIT] &&
                   (active_eff || bus_req.wdata[CTRL_ACTIVATE_BIT]);
  assign halt_fire = halt_exec && active_eff && opt_halt_q;
  assign fire = (expire_fire || sw_fire || halt_fire) && !pulsing_q;

  // Pulse timer; a new cause during a pulse is absorbed, not restarted.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pulsing_q <= 1'b0;
      pulse_q <= '0;
      sys_reset_n_q <= 1'b1;
    end else if (fire) begin
      pulsing_q <= 1'b1;
      pulse_q <= '0;
      sys_reset_n_q <= 1'b0;
    end else if (pulsing_q) begin
      if (pulse_q == RST_PULSE_LAST) begin
        pulsing_q <= 1'b0;
        sys_reset_n_q <= 1'b1;
      end else begin
        pulse_q <= pulse_q + 6'd1;
      end
    end
  end

  // ****************************************************************
  // Register read port and status
  // ****************************************************************
  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= READ_UNMAPPED;
    end else if (bus_req.rd && ctrl_sel) begin
      rdata_q <= {watchdog_activate_q, cnt_q};
    end else begin
      rdata_q <= READ_UNMAPPED;
    end
  end

  // Active indication mirrors activation or the permanent option.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wdg_active_q <= 1'b0;
    end else begin
      wdg_active_q <= watchdog_activate_q || opt_hw_q;
    end
  end

  // ****************************************************************
  // Assertion helpers
  // ****************************************************************
  // Length of the current low stretch of the reset line; a counter stands in
  // for a long repetition, and it saturates rather than wrapping.
  always_ff @(posedge core_clk) begin
    if (reset || sys_reset_n_q) begin
      low_run_q <= '0;
    end else if (!(&low_run_q)) begin
      low_run_q <= low_run_q + 7'd1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // A step lowers the counter by exactly one.
  property p_step_dec;
    step && !ctrl_wr |=> cnt_q == $past(cnt_q) - 7'd1;
  endproperty
  a_step_dec: assert property (p_step_dec)
    else $error("Counter did not decrement on a step.");

  // Without step or write the counter holds.
  property p_hold;
    !step && !ctrl_wr |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Counter changed without a step.");

  // A write loads all seven counter bits.
  property p_load;
    ctrl_wr |=> cnt_q == $past(bus_req.wdata[6:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("Write did not load the counter.");

  // Expiry while active drops the reset line next cycle.
  property p_expire;
    active_eff && step && !ctrl_wr && cnt_q == COUNT_EXPIRE && !pulsing_q
      |=> !sys_reset_n_q;
  endproperty
  a_expire: assert property (p_expire)
    else $error("Expiry did not start a reset.");

  // The reset pulse lasts exactly fifty cycles.
  property p_pulse_len;
    $fell(sys_reset_n_q) |-> !sys_reset_n_q [*8] ##42 !sys_reset_n_q ##1 sys_reset_n_q;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Reset pulse length is wrong.");

  // Activation never clears outside reset.
  property p_sticky;
    watchdog_activate_q |=> watchdog_activate_q;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Activation bit cleared without reset.");

  // A write with activation set and top bit clear resets at once.
  property p_sw_reset;
    ctrl_wr && bus_req.wdata[CTRL_ACTIVATE_BIT] && !bus_req.wdata[CTRL_TOP_BIT] &&
      !pulsing_q |=> !sys_reset_n_q;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("Software reset did not fire.");

  // Halt with the option and activation resets.
  property p_halt;
    halt_exec && opt_halt_q && active_eff && !pulsing_q |=> !sys_reset_n_q;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Halt did not reset.");

  // Inactive watchdog never drives reset.
  property p_quiet;
    !active_eff && !(ctrl_wr && bus_req.wdata[CTRL_ACTIVATE_BIT]) && !pulsing_q
      |=> sys_reset_n_q;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Reset driven while inactive.");

  // A read returns the register contents of the read cycle.
  property p_read;
    bus_req.rd && ctrl_sel |=> rdata_q == {$past(watchdog_activate_q), $past(cnt_q)};
  endproperty
  a_read: assert property (p_read)
    else $error("Read data do not match the register.");

  // Every cycle of the pulse is low, not only its two ends.
  property p_pulse_run;
    $rose(sys_reset_n_q) |-> low_run_q == 7'(RST_PULSE_CYC);
  endproperty
  a_pulse_run: assert property (p_pulse_run)
    else $error("Reset pulse was not low for its full length.");

  // The active indication follows activation or the permanent option.
  property p_active_out;
    !reset |=> wdg_active_q == $past(active_eff);
  endproperty
  a_active_out: assert property (p_active_out)
    else $error("Active indication does not follow activation.");

  // Outside the cycle after a read the read port shows nothing.
  property p_read_idle;
    !reset && !(bus_req.rd && ctrl_sel) |=> rdata_q == READ_UNMAPPED;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("Read data stood longer than one cycle.");

  // A write never disturbs the prescaler phase.
  property p_pre_run;
    !reset && osc_tick && !step |=> pre_q == $past(pre_q) + 15'd1;
  endproperty
  a_pre_run: assert property (p_pre_run)
    else $error("Prescaler did not advance on an oscillator tick.");

  // Without an oscillator tick the prescaler stands still.
  property p_pre_stall;
    !reset && !osc_tick |=> $stable(pre_q);
  endproperty
  a_pre_stall: assert property (p_pre_stall)
    else $error("Prescaler moved without an oscillator tick.");

  // An ordinary step is followed by a full-length one.
  property p_period_base;
    step && !boundary |=> period_q == PRESCALE_BASE;
  endproperty
  a_period_base: assert property (p_period_base)
    else $error("Ordinary step length is wrong.");

  // A step that crosses a timebase boundary is followed by one lasting (192+LSB)x64 ticks.
  property p_period_alt;
    step && boundary |=> period_q ==
      ({7'h00, ALT_PERIOD_ADD} + {9'h000, $past(tb_lsb)}) << ALT_PERIOD_SHIFT;
  endproperty
  a_period_alt: assert property (p_period_alt)
    else $error("Boundary step length is wrong.");

  // Only a write with the activation bit set can set watchdog_activate_q; the permanent option activates without it.
  property p_act_set_only;
    !reset && !watchdog_activate_q && !(ctrl_wr && bus_req.wdata[CTRL_ACTIVATE_BIT])
      |=> !watchdog_activate_q;
  endproperty
  a_act_set_only: assert property (p_act_set_only)
    else $error("Activation set without a write.");

endmodule

// File: bench/wdr_testbench.sv
// Purpose: Self-checking bench for the watchdog down-counter and its reset output.
// Assumes: osc_tick is high every cycle but for one stall, so an ordinary step is 16384 core cycles; a boundary step is shorter.
// Notes: Each scenario restarts the block, since only a reset clears activation.
`timescale 1ns/1ps
module testbench;
  import wdr_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  wdr_bus_req_t bus_req = '0;
  logic osc_tick = 1'b1;
  wdr_tb_t timebase_select = WDR_TB_2MS;
  logic halt_exec = 1'b0;
  logic opt_hw_watchdog = 1'b0;
  logic opt_halt_reset = 1'b0;
  logic [7:0] rdata_q;
  logic sys_reset_n_q;
  logic wdg_active_q;
  int error_cnt = 0;
  int n_checks = 0;

  // Free-running core clock at 100 MHz.
  always #5 core_clk = ~core_clk;

  wdr_watchdog u_dut (
    .core_clk(core_clk),
    .reset(reset),
    .bus_req(bus_req),
    .osc_tick(osc_tick),
    .timebase_select(timebase_select),
    .halt_exec(halt_exec),
    .opt_hw_watchdog(opt_hw_watchdog),
    .opt_halt_reset(opt_halt_reset),
    .rdata_q(rdata_q),
    .sys_reset_n_q(sys_reset_n_q),
    .wdg_active_q(wdg_active_q)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Strobes drop one edge later, so a following request never lands in the same cycle.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample right there.
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask

  task automatic restart(input logic hw, input logic hlt, input wdr_tb_t tb);
    @(posedge core_clk);
    reset <= 1'b1;
    opt_hw_watchdog <= hw;
    opt_halt_reset <= hlt;
    timebase_select <= tb;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    #1;
  endtask

  task automatic halt_pulse();
    @(posedge core_clk);
    halt_exec <= 1'b1;
    @(posedge core_clk);
    halt_exec <= 1'b0;
    #1;
  endtask

  // Counts the cycles of a reset pulse that is already low; bounded against a stuck output.
  task automatic pulse_chk();
    int n;
    n = 0;
    while (sys_reset_n_q === 1'b0 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk8(8'(n), 8'(RST_PULSE_CYC));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [7:0] v;
    restart(1'b0, 1'b0, WDR_TB_2MS);
    bus_rd(8'h00, v);
    chk8(v, 8'h7f);
    chk1(wdg_active_q, 1'b0);
    bus_wr(8'h05, 8'h80);
    bus_rd(8'h05, v);
    chk8(v, 8'h00);
    bus_rd(8'h00, v);
    chk8(v, 8'h7f);
    bus_wr(8'h00, 8'hff);
    bus_rd(8'h00, v);
    chk8(v, 8'hff);
    bus_wr(8'h00, 8'h7f);
    bus_rd(8'h00, v);
    chk8(v, 8'hff);
    chk1(wdg_active_q, 1'b1);
    chk1(sys_reset_n_q, 1'b1);
  endtask

  // Inactive counter must still step from 40h to 3Fh, and without any reset.
  task automatic t_freerun();
    logic [7:0] v;
    logic seen_low;
    int k;
    int span;
    restart(1'b0, 1'b0, WDR_TB_2MS);
    bus_wr(8'h00, 8'h40);
    // Stall the oscillator enable for 100 cycles; the step must slip by as much.
    @(posedge core_clk);
    osc_tick <= 1'b0;
    repeat (100) @(posedge core_clk);
    osc_tick <= 1'b1;
    seen_low = 1'b0;
    k = 0;
    v = 8'h40;
    while (v === 8'h40 && k < 9000) begin
      bus_rd(8'h00, v);
      seen_low |= ~sys_reset_n_q;
      k++;
    end
    // Cycles from the write edge to the read that saw the step; the step lands
    // 16384 ticks after release, two cycles before the write, plus the stall.
    span = 101 + 2 * k;
    chk8(v, 8'h3f);
    chk1(span > 16384 - 2 + 100 && span <= 16384 + 100, 1'b1);
    chk1(seen_low, 1'b0);
  endtask

  // The write lands two cycles after release, so the first step is 16382 cycles
  // away; on the shortest timebase a count of one also crosses a boundary step.
  task automatic t_timeout(input wdr_tb_t tb);
    int n;
    int exp_n;
    restart(1'b0, 1'b0, tb);
    if (tb == WDR_TB_2MS) begin
      bus_wr(8'h00, 8'hc1);
      exp_n = 16384 - 2 + (192 + 59) * 64;
    end else begin
      bus_wr(8'h00, 8'hc0);
      exp_n = 16384 - 2;
    end
    n = 0;
    while (sys_reset_n_q === 1'b1 && n < 33000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_cnt(n, exp_n);
    pulse_chk();
  endtask

  task automatic t_swreset();
    restart(1'b0, 1'b0, WDR_TB_2MS);
    bus_wr(8'h00, 8'h3f);
    chk1(sys_reset_n_q, 1'b1);
    bus_wr(8'h00, 8'h80);
    chk1(sys_reset_n_q, 1'b0);
    pulse_chk();
    bus_wr(8'h00, 8'h3f);
    chk1(sys_reset_n_q, 1'b0);
    pulse_chk();
  endtask

  task automatic t_halt();
    restart(1'b0, 1'b1, WDR_TB_2MS);
    halt_pulse();
    chk1(sys_reset_n_q, 1'b1);
    bus_wr(8'h00, 8'hff);
    halt_pulse();
    chk1(sys_reset_n_q, 1'b0);
    pulse_chk();
    restart(1'b0, 1'b0, WDR_TB_2MS);
    bus_wr(8'h00, 8'hff);
    halt_pulse();
    chk1(sys_reset_n_q, 1'b1);
  endtask

  task automatic t_hw();
    restart(1'b1, 1'b0, WDR_TB_2MS);
    @(posedge core_clk);
    #1;
    chk1(wdg_active_q, 1'b1);
    bus_wr(8'h00, 8'h3f);
    chk1(sys_reset_n_q, 1'b0);
    pulse_chk();
  endtask

  // Watchdog: the whole run needs roughly 98700 cycles.
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end

  // Main sequence; every timebase code is run through the timeout path.
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_swreset();
    t_halt();
    t_hw();
    t_freerun();
    for (int i = 0; i < 4; i++) begin
      t_timeout(wdr_tb_t'(i));
    end
    give_verdict();
  end
endmodule
